// ===== shared/flash_host_pkg.sv
// shared constants for the boot-sector flash pin controller
package flash_host_pkg;
  // ************************************************************
  // clock and pin timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int CNT_W = 16;
  localparam int T_CE_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int T_READY_NS = 20000;
  // least times round up to whole cycles
  localparam logic [CNT_W-1:0] CE_CYC = CNT_W'((T_CE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RH_CYC = CNT_W'((T_RH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] READY_CYC = CNT_W'((T_READY_NS * CLK_MHZ + 999) / 1000);
  // busy input needs this many cycles to get through the synchroniser
  localparam logic [CNT_W-1:0] SYNC_LAT = 16'h0004;

  // ************************************************************
  // commands, sectors, data lanes
  // ************************************************************
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RESET = 2'h2;
  localparam int SEC_W = 6;
  localparam logic [4:0] SEC_TOP_BLK = 5'h1f;
  localparam logic [SEC_W-1:0] SEC_HALF = 6'h1f;
  localparam logic [SEC_W-1:0] SEC_PARAM0 = 6'h20;
  localparam logic [SEC_W-1:0] SEC_PARAM1 = 6'h21;
  localparam logic [SEC_W-1:0] SEC_BOOT = 6'h22;
  localparam logic [15:0] OE_ALL_OFF = 16'hffff;
  localparam logic [15:0] OE_WORD = 16'h0000;
  localparam logic [15:0] OE_BYTE = 16'h7f00;
  localparam logic [15:0] OE_LSB_ONLY = 16'h7fff;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_READ = 7'h02,
    ST_WRITE = 7'h04,
    ST_WREC = 7'h08,
    ST_RLOW = 7'h10,
    ST_RWAIT = 7'h20,
    ST_RREC = 7'h40
  } host_state_t;
endpackage

// ===== hdl/flash_host_ctrl.sv
// host-side pin controller for a parallel top-boot flash
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - host waits full chip-select access time before sampling read data.
// - host raises reissue_flag when reset is taken while the synchronised busy line shows busy; it does not redo the program itself.
// - host waits reset_high_recovery after reset release before reading.
// - byte mode addresses bits 19 down to A-1, word mode 19 down to 0.
module flash_host_ctrl #(
  parameter int ADDR_W = 20
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // user command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic cmd_lsb,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_byte_mode,
  output logic cmd_ready,
  // user answer port
  output logic rsp_done,
  output logic [15:0] rsp_rdata,
  output logic [flash_host_pkg::SEC_W-1:0] rsp_sector,
  output logic rsp_timeout,
  output logic reissue_flag,
  // flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic flash_byte_n,
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe_n,
  input wire logic ready_busy_n
);
  // ************************************************************
  // checks and decode
  // ************************************************************
  if (ADDR_W != 20) begin : g_addr_chk
    $error("flash_host_ctrl: sector decode needs ADDR_W of 20");
  end

  function automatic logic [flash_host_pkg::SEC_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    logic [flash_host_pkg::SEC_W-1:0] s;
    s = flash_host_pkg::SEC_BOOT;
    if (a[19:15] != flash_host_pkg::SEC_TOP_BLK) begin
      s = {1'b0, a[19:15]};
    end else if (!a[14]) begin
      s = flash_host_pkg::SEC_HALF;
    end else if (a[13:12] == 2'h0) begin
      s = flash_host_pkg::SEC_PARAM0;
    end else if (a[13:12] == 2'h1) begin
      s = flash_host_pkg::SEC_PARAM1;
    end
    return s;
  endfunction

  typedef struct packed {
    flash_host_pkg::host_state_t st;
    logic [flash_host_pkg::CNT_W-1:0] cnt;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic byte_n;
    logic byte_m;
    logic [ADDR_W-1:0] addr;
    logic [15:0] dq_o;
    logic [15:0] dq_oe_n;
    logic [15:0] rdata;
    logic [flash_host_pkg::SEC_W-1:0] sector;
    logic done;
    logic tmo;
    logic reissue;
    logic rdy;
    logic rb1;
    logic rb2;
    logic rb3;
    logic rb_f;
  } ctrl_state_t;

  // power-up leaves every pin idle so the device sits in array read
  localparam ctrl_state_t RESET_S = '{st: flash_host_pkg::ST_IDLE, cnt: '0, ce_n: 1'b1, oe_n: 1'b1,
    we_n: 1'b1, rst_n: 1'b1, byte_n: 1'b1, byte_m: 1'b0, addr: '0, dq_o: '0,
    dq_oe_n: flash_host_pkg::OE_ALL_OFF, rdata: '0, sector: '0, done: 1'b0, tmo: 1'b0,
    reissue: 1'b0, rdy: 1'b0, rb1: 1'b1, rb2: 1'b1, rb3: 1'b1, rb_f: 1'b1};

  ctrl_state_t q;
  ctrl_state_t n;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n = q;
    n.done = 1'b0;
    n.cnt = q.cnt + 16'h0001;
    // busy level arrives through three flops; change taken once two agree
    n.rb1 = ready_busy_n;
    n.rb2 = q.rb1;
    n.rb3 = q.rb2;
    if (q.rb2 == q.rb3) begin
      n.rb_f = q.rb3;
    end
    case (q.st)
      flash_host_pkg::ST_IDLE: begin
        n.rdy = 1'b1;
        n.cnt = '0;
        if (cmd_valid && q.rdy && cmd_op != 2'h3) begin
          n.rdy = 1'b0;
          n.addr = cmd_addr;
          n.byte_m = cmd_byte_mode;
          // width pin follows the command's mode
          n.byte_n = ~cmd_byte_mode;
          n.sector = sector_of(cmd_addr);
          n.tmo = 1'b0;
          // byte mode drives A-1 on line 15
          n.dq_o = {cmd_lsb, 15'h0000};
          n.dq_oe_n = cmd_byte_mode ? flash_host_pkg::OE_LSB_ONLY : flash_host_pkg::OE_ALL_OFF;
          if (cmd_op == flash_host_pkg::OP_READ) begin
            n.ce_n = 1'b0;
            n.oe_n = 1'b0;
            n.st = flash_host_pkg::ST_READ;
          end else if (cmd_op == flash_host_pkg::OP_WRITE) begin
            n.ce_n = 1'b0;
            n.we_n = 1'b0;
            n.dq_o = cmd_byte_mode ? {cmd_lsb, 7'h00, cmd_wdata[7:0]} : cmd_wdata;
            n.dq_oe_n = cmd_byte_mode ? flash_host_pkg::OE_BYTE : flash_host_pkg::OE_WORD;
            n.reissue = 1'b0;
            n.st = flash_host_pkg::ST_WRITE;
          end else begin
            // reset over a busy device means the operation must be redone
            if (!q.rb_f) begin
              n.reissue = 1'b1;
            end
            n.rst_n = 1'b0;
            n.dq_oe_n = flash_host_pkg::OE_ALL_OFF;
            n.st = flash_host_pkg::ST_RLOW;
          end
        end
      end
      flash_host_pkg::ST_READ: begin
        // sample only after the whole chip-select access time
        if (q.cnt == flash_host_pkg::CE_CYC - 16'h0001) begin
          n.rdata = q.byte_m ? {8'h00, dq_in[7:0]} : dq_in;
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          n.dq_oe_n = flash_host_pkg::OE_ALL_OFF;
          n.done = 1'b1;
          n.rdy = 1'b1;
          n.st = flash_host_pkg::ST_IDLE;
        end
      end
      flash_host_pkg::ST_WRITE: begin
        if (q.cnt == flash_host_pkg::WP_CYC - 16'h0001) begin
          n.we_n = 1'b1;
          n.cnt = '0;
          n.st = flash_host_pkg::ST_WREC;
        end
      end
      flash_host_pkg::ST_WREC: begin
        // data held one cycle past the strobe edge; device carries on alone
        n.ce_n = 1'b1;
        n.dq_oe_n = flash_host_pkg::OE_ALL_OFF;
        n.done = 1'b1;
        n.rdy = 1'b1;
        n.st = flash_host_pkg::ST_IDLE;
      end
      flash_host_pkg::ST_RLOW: begin
        if (q.cnt == flash_host_pkg::RP_CYC - 16'h0001) begin
          n.rst_n = 1'b1;
          n.cnt = '0;
          n.st = flash_host_pkg::ST_RWAIT;
        end
      end
      flash_host_pkg::ST_RWAIT: begin
        // wait out busy, bounded by the ready time; covers the idle case
        if (q.cnt >= flash_host_pkg::SYNC_LAT && q.rb_f) begin
          n.cnt = '0;
          n.st = flash_host_pkg::ST_RREC;
        end else if (q.cnt == flash_host_pkg::READY_CYC - 16'h0001) begin
          n.tmo = 1'b1;
          n.cnt = '0;
          n.st = flash_host_pkg::ST_RREC;
        end
      end
      flash_host_pkg::ST_RREC: begin
        // recovery gap before the next read; device is back in array read
        if (q.cnt == flash_host_pkg::RH_CYC - 16'h0001) begin
          n.done = 1'b1;
          n.rdy = 1'b1;
          n.st = flash_host_pkg::ST_IDLE;
        end
      end
      default: begin
        n = RESET_S;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= RESET_S;
    end else if (clk_en) begin
      q <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign cmd_ready = q.rdy;
  assign rsp_done = q.done;
  assign rsp_rdata = q.rdata;
  assign rsp_sector = q.sector;
  assign rsp_timeout = q.tmo;
  assign reissue_flag = q.reissue;
  assign flash_ce_n = q.ce_n;
  assign flash_oe_n = q.oe_n;
  assign flash_we_n = q.we_n;
  assign flash_reset_n = q.rst_n;
  assign flash_byte_n = q.byte_n;
  assign flash_addr = q.addr;
  assign dq_out = q.dq_o;
  assign dq_oe_n = q.dq_oe_n;

  // ************************************************************
  // checks
  // ************************************************************
  logic [flash_host_pkg::CNT_W-1:0] oe_low_cnt;
  logic [flash_host_pkg::CNT_W-1:0] rst_low_cnt;
  logic [flash_host_pkg::CNT_W-1:0] since_rel;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      oe_low_cnt <= '0;
      rst_low_cnt <= '0;
      since_rel <= 16'hffff;
    end else if (clk_en) begin
      oe_low_cnt <= flash_oe_n ? '0 : oe_low_cnt + 16'h0001;
      rst_low_cnt <= flash_reset_n ? '0 : rst_low_cnt + 16'h0001;
      since_rel <= !flash_reset_n ? '0 : (since_rel == 16'hffff ? since_rel : since_rel + 16'h0001);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_READ_ACCESS: assert property ($rose(flash_oe_n) |-> oe_low_cnt >= flash_host_pkg::CE_CYC)
    else $error("read data sampled before access time");
  AST_RESET_WIDTH: assert property ($rose(flash_reset_n) |-> rst_low_cnt >= flash_host_pkg::RP_CYC)
    else $error("reset pulse too short");
  AST_RESET_QUIET: assert property (!flash_reset_n |-> flash_ce_n && flash_oe_n && flash_we_n && (&dq_oe_n))
    else $error("bus activity during reset");
  AST_RECOVERY: assert property ($fell(flash_oe_n) |-> since_rel >= flash_host_pkg::RH_CYC)
    else $error("read started inside reset recovery");
  AST_READ_NO_DRIVE: assert property (!flash_oe_n |-> (&dq_oe_n[14:0]))
    else $error("host drives data while device outputs");
  AST_BYTE_LANES: assert property (!flash_byte_n |-> (&dq_oe_n[14:8]) && (!dq_oe_n[15] || flash_ce_n))
    else $error("byte mode lane misuse");
  AST_SECTOR_MAP: assert property (rsp_done |-> rsp_sector == sector_of(flash_addr))
    else $error("sector index mismatch");
  AST_LSB_ADDR: assert property ((!flash_ce_n && !flash_byte_n && !$past(flash_ce_n))
    |-> dq_out[15] == $past(dq_out[15]))
    else $error("A-1 changed during a cycle");
  AST_WRITE_STROBE: assert property ($fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n && flash_oe_n)[*2])
    else $error("write strobe shape wrong");
  AST_REISSUE: assert property ((cmd_valid && cmd_ready && clk_en && cmd_op == flash_host_pkg::OP_RESET
    && !q.rb_f) |=> reissue_flag)
    else $error("interrupted operation not flagged");
endmodule // flash_host_ctrl
`default_nettype wire

// ===== verif/flash_dev_model.sv
// behavioural boot-sector flash device seen from the host pins
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int BUSY_CYC = 40,
  parameter int RST_CYC = 80
) (
  // timer clock
  input wire logic clock,
  // control pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic byte_n,
  input wire logic [19:0] addr,
  // data and status pins
  input wire logic [15:0] dq_out,
  input wire logic [15:0] dq_oe_n,
  output logic [15:0] dq_in,
  output logic ready_busy_n
);
  // arbitrary status pattern
  localparam logic [7:0] STAT = 8'h4c;
  logic [15:0] mem [16];
  logic [15:0] pend_d;
  logic [15:0] dev;
  logic [15:0] en;
  logic [15:0] flip = 16'h0000;
  logic [3:0] pend_a;
  logic pend = 1'b0;
  logic pend_b;
  logic we_q = 1'b1;
  int busy_cnt = 0;
  // ************************************************************
  // array and embedded program
  // ************************************************************
  // array read at start
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h5a00 | 16'(i);
  always @(posedge clock) begin
    flip <= ~flip;
    we_q <= we_n;
    // abort, busy until internal reset ends
    if (!reset_n && pend) begin
      pend <= 1'b0;
      busy_cnt <= RST_CYC;
    end else if (reset_n && !ce_n && we_n && !we_q && busy_cnt == 0) begin
      pend <= 1'b1;
      pend_a <= addr[3:0];
      pend_d <= dq_out;
      pend_b <= !byte_n;
      busy_cnt <= BUSY_CYC;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1 && pend) begin
        pend <= 1'b0;
        if (!pend_b) mem[pend_a] <= pend_d;
        else if (pend_d[15]) mem[pend_a][15:8] <= pend_d[7:0];
        else mem[pend_a][7:0] <= pend_d[7:0];
      end
    end
  end
  // status while busy, else data held while address stable
  assign dev = busy_cnt != 0 ? {8'h00, STAT} : (byte_n ? mem[addr[3:0]] :
    {8'h00, dq_out[15] ? mem[addr[3:0]][15:8] : mem[addr[3:0]][7:0]});
  // drive only selected, gated, out of reset
  assign en = (!ce_n && !oe_n && reset_n) ? (byte_n ? 16'hffff : 16'h00ff) : 16'h0000;
  // released lines toggle so no stale value reads back
  assign dq_in = (~dq_oe_n & dq_out) | (dq_oe_n & en & dev) | (dq_oe_n & ~en & flip);
  assign ready_busy_n = busy_cnt == 0;
endmodule // flash_dev_model
`default_nettype wire

// ===== verif/flash_mode_reset_sector_map_test.sv
// self-checking bench for the flash pin controller
`timescale 1ns/1ps
`default_nettype none
module flash_mode_reset_sector_map_test;
  logic clock = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, cmd_valid = 1'b0, cmd_lsb = 1'b0, cmd_byte_mode = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [19:0] cmd_addr = 20'h00000, faddr;
  logic [15:0] cmd_wdata = 16'h0000, rsp_rdata, dq_in, dq_out, dq_oe_n, mid_oe;
  logic cmd_ready, rsp_done, rsp_timeout, reissue_flag, ce_n, oe_n, we_n, rst_n, byte_n, ready_busy_n, mid_rst;
  logic [5:0] rsp_sector;
  logic hold_busy = 1'b0;
  int num_errors = 0, tests_run = 0, cycles = 0, lat;
  localparam logic [19:0] SA [8] = '{20'h00000, 20'h08000, 20'hf0000, 20'hf8000, 20'hfc000, 20'hfd000,
    20'hfe000, 20'hff000};
  localparam logic [5:0] SX [8] = '{6'h00, 6'h01, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h22};
  flash_host_ctrl dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_lsb(cmd_lsb), .cmd_wdata(cmd_wdata),
    .cmd_byte_mode(cmd_byte_mode), .cmd_ready(cmd_ready), .rsp_done(rsp_done), .rsp_rdata(rsp_rdata),
    .rsp_sector(rsp_sector), .rsp_timeout(rsp_timeout), .reissue_flag(reissue_flag), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n), .flash_byte_n(byte_n), .flash_addr(faddr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ready_busy_n(ready_busy_n & ~hold_busy));
  flash_dev_model flash_dev (.clock(clock), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n),
    .byte_n(byte_n), .addr(faddr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in),
    .ready_busy_n(ready_busy_n));
  initial forever #5 clock = ~clock;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one command, held until taken, then timed to its done pulse
  task automatic issue(input logic [1:0] op, input logic [19:0] a, input logic [15:0] d, input logic bm,
    input logic lsb);
    @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_byte_mode = bm;
    cmd_lsb = lsb;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    mid_oe = dq_oe_n;
    mid_rst = rst_n;
    lat = 0;
    while (rsp_done !== 1'b1) begin
      @(negedge clock);
      lat++;
    end
  endtask
  task automatic wait_ready;
    while (ready_busy_n !== 1'b1) @(negedge clock);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_word;
    issue(2'h0, 20'h00003, 16'h0000, 1'b0, 1'b0);
    check("first read", rsp_rdata, 16'h5a03);
    check("read latency", lat, 7);
    issue(2'h1, 20'h00005, 16'hc3a5, 1'b0, 1'b0);
    check("write latency", lat, 5);
    check("word write lanes", mid_oe, 16'h0000);
    issue(2'h0, 20'h00005, 16'h0000, 1'b0, 1'b0);
    check("busy status", rsp_rdata, 16'h004c);
    wait_ready();
    issue(2'h0, 20'h00005, 16'h0000, 1'b0, 1'b0);
    check("programmed word", rsp_rdata, 16'hc3a5);
    check("word read lanes", mid_oe, 16'hffff);
    $display("test word done");
  endtask
  task automatic t_byte;
    issue(2'h1, 20'h00006, 16'h0077, 1'b1, 1'b1);
    check("byte write lanes", mid_oe, 16'h7f00);
    wait_ready();
    issue(2'h0, 20'h00006, 16'h0000, 1'b1, 1'b1);
    check("byte hi", rsp_rdata, 16'h0077);
    check("byte read lanes", mid_oe, 16'h7fff);
    issue(2'h0, 20'h00006, 16'h0000, 1'b1, 1'b0);
    check("byte lo", rsp_rdata, 16'h0006);
    $display("test byte done");
  endtask
  task automatic t_sector;
    for (int i = 0; i < 8; i++) begin
      issue(2'h0, SA[i], 16'h0000, 1'b0, 1'b0);
      check("sector", rsp_sector, SX[i]);
    end
    $display("test sector done");
  endtask
  task automatic t_reset;
    issue(2'h1, 20'h00007, 16'h1111, 1'b0, 1'b0);
    repeat (6) @(negedge clock);
    issue(2'h2, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check("reset pin low", mid_rst, 1'b0);
    check("reset lanes", mid_oe, 16'hffff);
    check("reissue", reissue_flag, 1'b1);
    check("busy wait", lat >= 85, 1'b1);
    check("no timeout", rsp_timeout, 1'b0);
    issue(2'h0, 20'h00007, 16'h0000, 1'b0, 1'b0);
    check("aborted word", rsp_rdata, 16'h5a07);
    issue(2'h1, 20'h00007, 16'h1111, 1'b0, 1'b0);
    check("reissue clear", reissue_flag, 1'b0);
    wait_ready();
    issue(2'h0, 20'h00007, 16'h0000, 1'b0, 1'b0);
    check("reissued word", rsp_rdata, 16'h1111);
    issue(2'h2, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check("idle reissue", reissue_flag, 1'b0);
    check("idle timeout", rsp_timeout, 1'b0);
    $display("test reset done");
  endtask
  // busy stuck low forces the ready-time limit; then a read frozen by clk_en
  task automatic t_stall;
    hold_busy = 1'b1;
    repeat (6) @(negedge clock);
    issue(2'h2, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check("stall wait", lat, flash_host_pkg::RP_CYC + flash_host_pkg::READY_CYC + flash_host_pkg::RH_CYC);
    check("stall timeout", rsp_timeout, 1'b1);
    check("stall reissue", reissue_flag, 1'b1);
    hold_busy = 1'b0;
    fork
      issue(2'h0, 20'h00003, 16'h0000, 1'b0, 1'b0);
      begin
        repeat (3) @(negedge clock);
        clk_en = 1'b0;
        repeat (4) @(negedge clock);
        clk_en = 1'b1;
      end
    join
    check("frozen read", rsp_rdata, 16'h5a03);
    check("frozen latency", lat, 11);
    check("timeout clear", rsp_timeout, 1'b0);
    $display("test stall done");
  endtask
  // hang guard, far above the few thousand cycles the run takes
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    t_word();
    t_byte();
    t_sector();
    t_reset();
    t_stall();
    give_verdict();
  end
endmodule // flash_mode_reset_sector_map_test
`default_nettype wire
